// [tb.sv]
// tb.sv: self-checking bench of the usb port path selector.
// assumes the design, its header, the bus model and the checker.
`timescale 1ns/100ps
`include "usbps_consts.vh"
module tb;
  localparam SETTLE = 20; // short settle keeps the run brief
  reg clk_in = 1'b0;
  reg rst_b_in = 1'b0;
  reg usb_attach_in = 1'b0;
  reg m_att = 1'b0;
  reg m_man = 1'b0;
  reg [7:0] m_path = 8'h00;
  reg [15:0] lf = 16'hacff;
  reg [7:0] rv;
  integer bad_count = 0;
  integer n_checks = 0;
  integer cyc = 0;
  integer i;
  wire scl_w, m_oe, sda_oe, sda_o, hp, hm, ur, ut, att, man;
  // pull-up; the slave's drive value counts only while its enable is high
  wire sda_w = !m_oe & (!sda_oe | sda_o);
  always #2 clk_in = !clk_in;
  usbps_path_select #(.SETTLE_CYCLES(SETTLE)) usbps_path_select_inst (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .usb_attach_in(usb_attach_in),
    .host_plus_out(hp), .host_minus_out(hm), .uart_rx_plus_out(ur),
    .uart_tx_minus_out(ut), .attach_seen_out(att), .manual_mode_out(man));
  usbps_i2c_master usbps_i2c_master_inst (.clk_in(clk_in),
    .sda_in(sda_w), .scl_out(scl_w), .sda_oe_out(m_oe));
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input [63:0] nm, input [7:0] id, input [7:0] e, input [7:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
        bad_count = bad_count + 1;
        $display("[ERR] %0s %h exp %h got %h", nm, id, e, g);
      end
    end
  endtask
  task chk_route;
    begin
      repeat (6) @(posedge clk_in);
      #1;
      chk("routes", 8'h00, {2'b00, m_att, m_man, {2{m_att & !m_man}},
        {2{m_man & (m_path == `USBPS_PATH_UART)}}},
        {2'b00, att, man, hp, hm, ur, ut});
    end
  endtask
  task rd_chk(input [7:0] p, input [7:0] e);
    begin
      usbps_i2c_master_inst.rd(p, rv);
      chk("register", p, e, rv);
    end
  endtask
  task wr(input [7:0] p, input [7:0] d);
    usbps_i2c_master_inst.wr(p, d);
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // a full run is near 7550 cycles
  always @(posedge clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 30000)
    begin
      bad_count = bad_count + 1;
      stop_test;
    end
  end
  initial
  begin
    repeat (10) @(posedge clk_in);
    #1;
    rst_b_in = 1'b1;
    chk_route;
    rd_chk(`USBPS_REG_SWITCH_CONTROL, `USBPS_CTRL_RESET);
    rd_chk(`USBPS_REG_MANUAL_PATH, `USBPS_PATH_RESET);
    $display("test reset done");
    usb_attach_in = 1'b1;
    m_att = 1'b1;
    chk_route;
    rd_chk(`USBPS_REG_STATUS, 8'h01);
    for (i = 0; i < 4; i = i + 1)
    begin
      lf = lfsr(lf);
      m_path = i ? lf[7:0] : `USBPS_PATH_UART;
      wr(`USBPS_REG_MANUAL_PATH, m_path);
      chk_route;
    end
    rd_chk(`USBPS_REG_MANUAL_PATH, m_path);
    $display("test automatic routing done");
    wr(`USBPS_REG_SWITCH_CONTROL, `USBPS_CTRL_MANUAL);
    m_man = 1'b1;
    chk_route;
    // software side of the settle wait, before the path code is written
    repeat (SETTLE) @(posedge clk_in);
    #1;
    rd_chk(`USBPS_REG_STATUS, 8'h07);
    wr(`USBPS_REG_MANUAL_PATH, `USBPS_PATH_UART);
    m_path = `USBPS_PATH_UART;
    chk_route;
    wr(`USBPS_REG_SWITCH_CONTROL, `USBPS_CTRL_AUTO);
    m_man = 1'b0;
    chk_route;
    $display("test manual sequence done");
    usb_attach_in = 1'b0;
    m_att = 1'b0;
    chk_route;
    wr(8'h40, lf[15:8]);
    rd_chk(8'h40, 8'h00);
    chk("nacks", 8'h00, 8'h00, usbps_i2c_master_inst.nack_count[7:0]);
    $display("test detach and unmapped done");
    stop_test;
  end
endmodule // tb
bind usbps_path_select usbps_path_select_assertions
  usbps_path_select_assertions_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .host_plus_out(host_plus_out), .host_minus_out(host_minus_out),
  .uart_rx_plus_out(uart_rx_plus_out), .attach_seen_out(attach_seen_out),
  .uart_tx_minus_out(uart_tx_minus_out), .manual_mode_out(manual_mode_out));

// [usbps_consts.vh]
// usbps_consts.vh: offsets, codes, reset values and timing of the usb
// port path selector. Included by every design file of the block.
`ifndef USBPS_CONSTS_VH
`define USBPS_CONSTS_VH

// register offsets on the serial management bus
`define USBPS_REG_SWITCH_CONTROL 8'h02
`define USBPS_REG_MANUAL_PATH 8'h13
`define USBPS_REG_STATUS 8'h0A

// control and path codes
`define USBPS_CTRL_MANUAL 8'h1A
`define USBPS_CTRL_AUTO 8'h1E
`define USBPS_PATH_UART 8'h6C

// reset values
`define USBPS_CTRL_RESET 8'h1E
`define USBPS_PATH_RESET 8'h00

// serial slave address, arbitrary value
`define USBPS_SLAVE_ADDR 7'h25

// status register bit positions
`define USBPS_STAT_ATTACHED 0
`define USBPS_STAT_MANUAL 1
`define USBPS_STAT_SETTLED 2

// settle time before the manual path may close
`define USBPS_SETTLE_US 125
`define USBPS_CLK_MHZ 250
`define USBPS_SETTLE_CYCLES (`USBPS_SETTLE_US * `USBPS_CLK_MHZ)

`endif

// [usbps_i2c_master.sv]
// usbps_i2c_master.sv: processor model driving the serial bus.
// assumes sda_in is the resolved wire with a pull-up; scl idles high.
`timescale 1ns/100ps
`include "usbps_consts.vh"
module usbps_i2c_master (
  input wire clk_in,            // clock
  input wire sda_in,            // resolved sda level
  output reg scl_out = 1'b1,    // serial clock
  output reg sda_oe_out = 1'b0  // high while pulling sda low
);
  localparam Q = 4; // quarter bit: scl phases of 8 clk, slave needs 4
  integer nack_count = 0;
  reg [8:0] r_d;
  task w(input integer n);
    begin
      repeat (n) @(posedge clk_in);
      #1;
    end
  endtask
  // steps alternate sda then scl: 0110 is a start, 1101 a stop
  task seq(input [3:0] s);
    integer k;
    for (k = 3; k >= 0; k = k - 1)
    begin
      w(Q);
      if (k[0])
        sda_oe_out = s[k];
      else
        scl_out = s[k];
    end
  endtask
  task xbyte(input [8:0] v, output [8:0] r);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1)
      begin
        w(Q);
        sda_oe_out = !v[i];
        w(Q);
        scl_out = 1'b1;
        w(2 * Q);
        r[i] = sda_in;
        scl_out = 1'b0;
      end
      if (v[8:1] !== 8'hff && r[0] !== 1'b0)
        nack_count = nack_count + 1;
    end
  endtask
  task wr(input [7:0] p, input [7:0] d);
    begin
      seq(4'b0110);
      xbyte({`USBPS_SLAVE_ADDR, 2'b01}, r_d);
      xbyte({p, 1'b1}, r_d);
      xbyte({d, 1'b1}, r_d);
      seq(4'b1101);
    end
  endtask
  task rd(input [7:0] p, output [7:0] d);
    begin
      seq(4'b0110);
      xbyte({`USBPS_SLAVE_ADDR, 2'b01}, r_d);
      xbyte({p, 1'b1}, r_d);
      seq(4'b0110);
      xbyte({`USBPS_SLAVE_ADDR, 2'b11}, r_d);
      xbyte(9'h1ff, r_d);
      d = r_d[8:1];
      seq(4'b1101);
    end
  endtask
endmodule // usbps_i2c_master

// [usbps_path_select.v]
// usbps_path_select.v: serial management slave, control registers and
// connector data-line routing of the usb port path selector.
// assumes scl/sda and the attach level are asynchronous pins; the sda wire
// is resolved outside from sda_oe_out (sda_out is always low).
`timescale 1ns/100ps
`include "usbps_consts.vh"

// Operation
// - A usb attach in automatic mode closes the host pair by itself.
// - Writing 1A to register 02 selects manual mode, opening the host pair.
// - Manual mode with code 6C joins uart rx to plus and tx to minus.
// - Writing 1E to register 02 returns to automatic routing.
module usbps_path_select #(
  parameter SETTLE_CYCLES = `USBPS_SETTLE_CYCLES
) (
  input wire clk_in,             // block clock, 250 MHz
  input wire rst_b_in,           // async reset, active low
  input wire scl_in,             // serial clock pin
  input wire sda_in,             // serial data pin level
  output wire sda_out,           // serial data drive value, always low
  output reg sda_oe_out,         // high while pulling sda low
  input wire usb_attach_in,      // usb accessory detected, async level
  output wire host_plus_out,     // connector plus to host usb plus
  output wire host_minus_out,    // connector minus to host usb minus
  output wire uart_rx_plus_out,  // uart receive to connector plus
  output wire uart_tx_minus_out, // uart transmit to connector minus
  output reg attach_seen_out,    // attach signalled to the processor
  output reg manual_mode_out     // manual switching active
);

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_ACK = 6'h04;
  localparam [5:0] ST_RX = 6'h08;
  localparam [5:0] ST_TX = 6'h10;
  localparam [5:0] ST_RACK = 6'h20;

  reg [2:0] scl_sync;
  reg [2:0] sda_sync;
  reg [1:0] att_sync;
  reg [5:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] ptr;
  reg ack_on;
  reg is_read;
  reg have_ptr;
  reg wr_stb;
  reg [7:0] wr_addr;
  reg [7:0] wr_data;
  reg [7:0] switch_control;
  reg [7:0] manual_path_select;
  reg enter_manual;
  reg [7:0] rd_data;
  wire scl_s;
  wire sda_s;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire [7:0] rx_byte;
  wire settled;

  // index 0 is the first flop; only index 1 reads it
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      att_sync <= 2'h0;
    end
    else
    begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      att_sync <= {att_sync[0], usb_attach_in};
    end
  end

  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign scl_rise = scl_s & ~scl_sync[2];
  assign scl_fall = ~scl_s & scl_sync[2];
  assign start_cond = scl_s & scl_sync[2] & sda_sync[2] & ~sda_s;
  assign stop_cond = scl_s & scl_sync[2] & ~sda_sync[2] & sda_s;
  assign rx_byte = {shreg[6:0], sda_s};
  assign sda_out = 1'b0;

  // read decode; unmapped offsets read as zero
  always @*
  begin
    case (ptr)
      `USBPS_REG_SWITCH_CONTROL: rd_data = switch_control;
      `USBPS_REG_MANUAL_PATH: rd_data = manual_path_select;
      `USBPS_REG_STATUS:
      begin
        rd_data = 8'h00;
        rd_data[`USBPS_STAT_ATTACHED] = attach_seen_out;
        rd_data[`USBPS_STAT_MANUAL] = manual_mode_out;
        rd_data[`USBPS_STAT_SETTLED] = settled;
      end
      default: rd_data = 8'h00;
    endcase
  end

  // serial slave: address, register pointer, then data bytes
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      ack_on <= 1'b0;
      is_read <= 1'b0;
      have_ptr <= 1'b0;
      sda_oe_out <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_stb <= 1'b0;
      if (start_cond)
      begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        have_ptr <= 1'b0;
        ack_on <= 1'b0;
        sda_oe_out <= 1'b0;
      end
      else if (stop_cond)
      begin
        state <= ST_IDLE;
        ack_on <= 1'b0;
        sda_oe_out <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (state)
          ST_ADDR, ST_RX:
          begin
            shreg <= rx_byte;
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'h7)
            begin
              if (state == ST_ADDR)
              begin
                is_read <= rx_byte[0];
                if (rx_byte[7:1] == `USBPS_SLAVE_ADDR)
                  state <= ST_ACK;
                else
                  state <= ST_IDLE;
              end
              else
              begin
                state <= ST_ACK;
                if (!have_ptr)
                begin
                  ptr <= rx_byte;
                  have_ptr <= 1'b1;
                end
                else
                begin
                  wr_stb <= 1'b1;
                  wr_addr <= ptr;
                  wr_data <= rx_byte;
                  ptr <= ptr + 8'h01;
                end
              end
            end
          end
          ST_TX:
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'h7)
              state <= ST_RACK;
          end
          ST_RACK:
          begin
            // a nack from the master ends the read
            if (!sda_s)
            begin
              state <= ST_TX;
              bit_cnt <= 4'h0;
              ptr <= ptr + 8'h01;
            end
            else
              state <= ST_IDLE;
          end
          default: ;
        endcase
      end
      else if (scl_fall)
      begin
        case (state)
          ST_ACK:
          begin
            if (!ack_on)
            begin
              ack_on <= 1'b1;
              sda_oe_out <= 1'b1;
            end
            else
            begin
              ack_on <= 1'b0;
              bit_cnt <= 4'h0;
              if (is_read)
              begin
                state <= ST_TX;
                shreg <= rd_data;
                sda_oe_out <= ~rd_data[7];
              end
              else
              begin
                state <= ST_RX;
                sda_oe_out <= 1'b0;
              end
            end
          end
          ST_TX:
          begin
            if (bit_cnt == 4'h0)
            begin
              shreg <= rd_data;
              sda_oe_out <= ~rd_data[7];
            end
            else
            begin
              shreg <= {shreg[6:0], 1'b0};
              sda_oe_out <= ~shreg[6];
            end
          end
          ST_RACK: sda_oe_out <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  // register writes and mode tracking
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      switch_control <= `USBPS_CTRL_RESET;
      manual_path_select <= `USBPS_PATH_RESET;
      manual_mode_out <= 1'b0;
      enter_manual <= 1'b0;
      attach_seen_out <= 1'b0;
    end
    else
    begin
      enter_manual <= 1'b0;
      attach_seen_out <= att_sync[1];
      if (wr_stb && wr_addr == `USBPS_REG_SWITCH_CONTROL)
      begin
        switch_control <= wr_data;
        // any value other than the manual code returns to automatic
        manual_mode_out <= (wr_data == `USBPS_CTRL_MANUAL);
        enter_manual <= (wr_data == `USBPS_CTRL_MANUAL);
      end
      if (wr_stb && wr_addr == `USBPS_REG_MANUAL_PATH)
        manual_path_select <= wr_data;
    end
  end

  usbps_route #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_route (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .attached_in(attach_seen_out),
    .manual_in(manual_mode_out),
    .enter_manual_in(enter_manual),
    .path_code_in(manual_path_select),
    .host_plus_out(host_plus_out),
    .host_minus_out(host_minus_out),
    .uart_rx_plus_out(uart_rx_plus_out),
    .uart_tx_minus_out(uart_tx_minus_out),
    .settled_out(settled)
  );

endmodule // usbps_path_select

// [usbps_path_select_assertions.sv]
// usbps_path_select_assertions.sv: port checks of the path selector.
// assumes a bind onto usbps_path_select, one clock, async low reset.
`timescale 1ns/100ps
module usbps_path_select_assertions (
  input wire clk_in,            // clock
  input wire rst_b_in,          // reset, active low
  input wire host_plus_out,     // host plus closed
  input wire host_minus_out,    // host minus closed
  input wire uart_rx_plus_out,  // uart rx closed
  input wire uart_tx_minus_out, // uart tx closed
  input wire attach_seen_out,   // attach signalled
  input wire manual_mode_out    // manual mode
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  property p_auto_host;
    attach_seen_out && !manual_mode_out |=> host_plus_out && host_minus_out;
  endproperty
  a_auto_host: assert property (p_auto_host)
    else $error("host pair open in automatic mode");
  property p_manual_open;
    manual_mode_out |=> !host_plus_out && !host_minus_out;
  endproperty
  a_manual_open: assert property (p_manual_open)
    else $error("host pair closed in manual mode");
  property p_uart_pair;
    uart_rx_plus_out |-> uart_tx_minus_out && $past(manual_mode_out);
  endproperty
  a_uart_pair: assert property (p_uart_pair)
    else $error("uart pair uneven or outside manual mode");
  property p_leave_manual;
    $fell(manual_mode_out) && attach_seen_out
      |=> host_minus_out && !uart_tx_minus_out;
  endproperty
  a_leave_manual: assert property (p_leave_manual)
    else $error("host pair not restored on leaving manual mode");
  property p_uart_gate;
    !manual_mode_out |=> !uart_rx_plus_out && !uart_tx_minus_out;
  endproperty
  a_uart_gate: assert property (p_uart_gate)
    else $error("uart pair closed in automatic mode");
  c_manual: cover property ($rose(manual_mode_out));
  c_uart: cover property ($rose(uart_rx_plus_out));
  c_return: cover property ($fell(manual_mode_out) && attach_seen_out);
endmodule // usbps_path_select_assertions

// [usbps_route.v]
// usbps_route.v: switch path decision and manual-mode settle timer.
// assumes synchronised inputs on clk_in and a write strobe one cycle wide.
`timescale 1ns/100ps
`include "usbps_consts.vh"

module usbps_route #(
  parameter SETTLE_CYCLES = `USBPS_SETTLE_CYCLES
) (
  input wire clk_in,            // block clock
  input wire rst_b_in,          // async reset, active low
  input wire attached_in,       // usb accessory present, synchronised
  input wire manual_in,         // manual switching selected
  input wire enter_manual_in,   // pulse: manual code written
  input wire [7:0] path_code_in, // manual path register
  output reg host_plus_out,     // connector plus to host usb plus
  output reg host_minus_out,    // connector minus to host usb minus
  output reg uart_rx_plus_out,  // uart receive to connector plus
  output reg uart_tx_minus_out, // uart transmit to connector minus
  output reg settled_out        // settle time since manual entry elapsed
);

  // counter is 16 bits: settle counts above 65535 are cut on purpose
  localparam [31:0] SETTLE_FULL = SETTLE_CYCLES;
  localparam [15:0] SETTLE_LAST = SETTLE_FULL[15:0] - 16'h0001;

  reg [15:0] settle_cnt;
  wire auto_usb;
  wire manual_uart;

  assign auto_usb = attached_in & ~manual_in;
  // path code is ignored while automatic
  assign manual_uart = manual_in &
    (path_code_in == `USBPS_PATH_UART);

  // status only: software owns the wait before writing the path code
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      settle_cnt <= 16'h0000;
      settled_out <= 1'b0;
    end
    else if (enter_manual_in)
    begin
      settle_cnt <= 16'h0000;
      settled_out <= 1'b0;
    end
    else if (manual_in && !settled_out)
    begin
      if (settle_cnt >= SETTLE_LAST)
        settled_out <= 1'b1;
      settle_cnt <= settle_cnt + 16'h0001;
    end
  end

  // manual entry with any other code opens every path
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      host_plus_out <= 1'b0;
      host_minus_out <= 1'b0;
      uart_rx_plus_out <= 1'b0;
      uart_tx_minus_out <= 1'b0;
    end
    else
    begin
      host_plus_out <= auto_usb;
      host_minus_out <= auto_usb;
      uart_rx_plus_out <= manual_uart;
      uart_tx_minus_out <= manual_uart;
    end
  end

endmodule // usbps_route
